// *** hw/sef_spi_front.sv ***
// SPI front end of a 4 KB page-organised serial EEPROM
`timescale 1ns/100ps
`default_nettype none
module sef_spi_front #(
	parameter int WR_CYCLES = sef_pkg::WR_CYCLES
) (
	// System clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Serial link
	input wire logic sclk_in,
	input wire logic sel_n_in,
	input wire logic mosi_in,
	input wire logic hold_n_in,
	input wire logic wp_n_in,
	output logic miso_out,
	output logic miso_oe_out,
	// Status
	output logic active_out,
	output logic busy_out
);
	sef_sync_if sync ();
	sef_pkg::sef_state_t st_reg;
	logic [2:0] bit_reg;
	logic [7:0] rx_reg, rx_next, tx_reg, sr_byte;
	logic [sef_pkg::ADDR_W-1:0] addr_reg, addr_new;
	logic [7:0] mem [0:sef_pkg::MEM_BYTES-1];
	logic ab_reg, rd_reg, standby_reg, drv_reg, miso_reg;
	logic wel_reg, bp_hi_reg, bp_lo_reg, tgl_reg;
	logic arm_s1_reg, armed_s2, busy_s1_reg, busy_s2;
	logic wp_s1_reg, wp_s2;
	logic go, byte_end;

	// ==========================================
	// Decode helpers
	function automatic logic cmd_ok(input logic [7:0] c, input logic busy);
		if (busy)
			cmd_ok = (c == sef_pkg::CMD_RDSR);
		else
			cmd_ok = (c == sef_pkg::CMD_READ) || (c == sef_pkg::CMD_WRITE) ||
				(c == sef_pkg::CMD_RDSR) || (c == sef_pkg::CMD_WRSR) ||
				(c == sef_pkg::CMD_WREN) || (c == sef_pkg::CMD_WRDI);
	endfunction
	function automatic logic prot(input logic [sef_pkg::ADDR_W-1:0] a, input logic hi, input logic lo);
		case ({hi, lo})
			2'h0: prot = 1'b0;
			2'h1: prot = (a[sef_pkg::ADDR_W-1 -: 2] == sef_pkg::TOP_QUARTER);
			2'h2: prot = a[sef_pkg::ADDR_W-1];
			default: prot = 1'b1;
		endcase
	endfunction

	// ==========================================
	// Master clock side
	sef_wr_timer #(
		.WR_CYCLES(WR_CYCLES)
	) u_timer (
		.mclk_in(mclk_in),
		.resetn_in(resetn_in),
		.sel_n_in(sel_n_in),
		.sync(sync.ctl)
	);
	assign busy_out = sync.busy;

	// ==========================================
	// Crossings into the link clock
	// The link clock only runs inside frames, so these settle over a frame's first edges
	always_ff @(posedge sclk_in) begin
		arm_s1_reg <= sync.armed;
		armed_s2 <= arm_s1_reg;
		busy_s1_reg <= sync.busy;
		busy_s2 <= busy_s1_reg;
		wp_s1_reg <= wp_n_in;
		wp_s2 <= wp_s1_reg;
	end

	// A held or unarmed edge neither shifts in a bit nor advances the frame
	assign go = !sel_n_in && hold_n_in && armed_s2;
	assign byte_end = go && (bit_reg == sef_pkg::BIT_LAST);
	assign rx_next = {rx_reg[6:0], mosi_in};
	assign addr_new = {addr_reg[sef_pkg::ADDR_W-1:8], rx_next};

	always_comb begin
		sr_byte = sef_pkg::SR_CLEAR;
		sr_byte[sef_pkg::SR_BUSY] = busy_s2;
		sr_byte[sef_pkg::SR_WEL] = wel_reg;
		sr_byte[sef_pkg::SR_BP_LO] = bp_lo_reg;
		sr_byte[sef_pkg::SR_BP_HI] = bp_hi_reg;
	end

	// ==========================================
	// Input shifter, rising edges
	always_ff @(posedge sclk_in) begin
		if (go)
			rx_reg <= rx_next;
	end

	// ==========================================
	// Frame sequencer; select high clears the frame
	always_ff @(posedge sclk_in or posedge sel_n_in) begin
		if (sel_n_in) begin
			st_reg <= sef_pkg::ST_CMD;
			bit_reg <= sef_pkg::BIT_FIRST;
			ab_reg <= 1'b0;
			rd_reg <= 1'b0;
			standby_reg <= 1'b0;
		end else if (go) begin
			bit_reg <= bit_reg + sef_pkg::BIT_ONE;
			if (bit_reg == sef_pkg::BIT_LAST) begin
				case (st_reg)
					sef_pkg::ST_CMD: begin
						if (!cmd_ok(rx_next, busy_s2)) begin
							standby_reg <= 1'b1;
							st_reg <= sef_pkg::ST_DONE;
						end else begin
							case (rx_next)
								sef_pkg::CMD_READ: begin
									st_reg <= sef_pkg::ST_ADDR;
									rd_reg <= 1'b1;
								end
								sef_pkg::CMD_WRITE: st_reg <= sef_pkg::ST_ADDR;
								sef_pkg::CMD_RDSR: st_reg <= sef_pkg::ST_RDATA;
								sef_pkg::CMD_WRSR: st_reg <= sef_pkg::ST_SRIN;
								default: st_reg <= sef_pkg::ST_DONE;
							endcase
						end
					end
					sef_pkg::ST_ADDR: begin
						ab_reg <= 1'b1;
						if (ab_reg)
							st_reg <= rd_reg ? sef_pkg::ST_RDATA : sef_pkg::ST_WDATA;
					end
					sef_pkg::ST_SRIN: st_reg <= sef_pkg::ST_DONE;
					default: st_reg <= st_reg;
				endcase
			end
		end
	end

	// ==========================================
	// Address, array and transmit byte
	// Bytes commit as they arrive; the busy window that follows the frame guards them
	always_ff @(posedge sclk_in) begin
		if (byte_end) begin
			case (st_reg)
				sef_pkg::ST_CMD: begin
					if (rx_next == sef_pkg::CMD_RDSR)
						tx_reg <= sr_byte;
				end
				sef_pkg::ST_ADDR: begin
					if (!ab_reg)
						addr_reg[sef_pkg::ADDR_W-1:8] <= rx_next[sef_pkg::ADDR_W-9:0];
					else begin
						tx_reg <= mem[addr_new];
						// Reads prefetch one byte ahead; writes land at the given address
						addr_reg <= rd_reg ? (addr_new + sef_pkg::ADDR_ONE) : addr_new;
					end
				end
				sef_pkg::ST_RDATA: begin
					if (rd_reg) begin
						tx_reg <= mem[addr_reg];
						addr_reg <= addr_reg + sef_pkg::ADDR_ONE;
					end else
						tx_reg <= sr_byte;
				end
				sef_pkg::ST_WDATA: begin
					if (wel_reg && !prot(addr_reg, bp_hi_reg, bp_lo_reg))
						mem[addr_reg] <= rx_next;
					addr_reg[sef_pkg::PAGE_W-1:0] <= addr_reg[sef_pkg::PAGE_W-1:0] + sef_pkg::PAGE_ONE;
				end
				default: tx_reg <= tx_reg;
			endcase
		end
	end

	// ==========================================
	// Write latch, protect bits and write-cycle request
	always_ff @(posedge sclk_in) begin
		if (!armed_s2 || busy_s2)
			wel_reg <= 1'b0;
		else if (byte_end && st_reg == sef_pkg::ST_CMD) begin
			if (rx_next == sef_pkg::CMD_WREN)
				wel_reg <= 1'b1;
			else if (rx_next == sef_pkg::CMD_WRDI)
				wel_reg <= 1'b0;
		end
	end
	always_ff @(posedge sclk_in) begin
		if (!armed_s2) begin
			bp_hi_reg <= 1'b0;
			bp_lo_reg <= 1'b0;
		end else if (byte_end && st_reg == sef_pkg::ST_SRIN && wel_reg && wp_s2) begin
			bp_hi_reg <= rx_next[sef_pkg::SR_BP_HI];
			bp_lo_reg <= rx_next[sef_pkg::SR_BP_LO];
		end
	end
	// Toggle, cleared only before arming, so the far side sees each request as a change
	always_ff @(posedge sclk_in) begin
		if (!armed_s2)
			tgl_reg <= 1'b0;
		else if (byte_end && wel_reg && (st_reg == sef_pkg::ST_WDATA || st_reg == sef_pkg::ST_SRIN))
			tgl_reg <= !tgl_reg;
	end
	assign sync.wr_tgl = tgl_reg;

	// ==========================================
	// Output stage, falling edges
	always_ff @(negedge sclk_in or posedge sel_n_in) begin
		if (sel_n_in) begin
			drv_reg <= 1'b0;
			miso_reg <= 1'b0;
		end else if (hold_n_in) begin
			drv_reg <= (st_reg == sef_pkg::ST_RDATA) && !standby_reg;
			miso_reg <= tx_reg[sef_pkg::BIT_LAST - bit_reg];
		end
	end
	assign miso_out = miso_reg;
	assign miso_oe_out = !sel_n_in && hold_n_in && drv_reg;
	assign active_out = !sel_n_in && !standby_reg;

	// ==========================================
	// Checks
	chk_first_sample: assert property (@(posedge sclk_in) disable iff (sel_n_in)
		(st_reg == sef_pkg::ST_CMD && bit_reg == sef_pkg::BIT_FIRST && hold_n_in && armed_s2)
		|=> bit_reg == sef_pkg::BIT_ONE)
		else $error("first bit not taken");
	chk_msb_in: assert property (@(posedge sclk_in) disable iff (sel_n_in)
		(go && st_reg == sef_pkg::ST_CMD) |=> rx_reg[0] == $past(mosi_in))
		else $error("input not shifted in order");
	chk_msb_out: assert property (@(posedge sclk_in) disable iff (sel_n_in)
		(drv_reg && st_reg == sef_pkg::ST_RDATA && bit_reg == sef_pkg::BIT_FIRST)
		|-> miso_reg == tx_reg[sef_pkg::BIT_LAST])
		else $error("output byte not led by top bit");
	chk_first_out: assert property (@(posedge sclk_in) disable iff (sel_n_in)
		(byte_end && st_reg == sef_pkg::ST_CMD && rx_next == sef_pkg::CMD_RDSR && !busy_s2)
		##1 hold_n_in |-> (st_reg == sef_pkg::ST_RDATA) && drv_reg)
		else $error("read data late");
	chk_deselect_hiz: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		sel_n_in |-> !miso_oe_out && !active_out)
		else $error("driving while deselected");
	chk_hold_hiz: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		!hold_n_in |-> !miso_oe_out)
		else $error("driving while paused");
	chk_hold_freeze: assert property (@(posedge sclk_in) disable iff (sel_n_in)
		!hold_n_in |=> $stable(bit_reg) && $stable(rx_reg) && $stable(st_reg))
		else $error("pause did not freeze transfer");
	chk_unarmed_idle: assert property (@(posedge sclk_in) disable iff (sel_n_in)
		!armed_s2 |=> $stable(bit_reg) && $stable(st_reg))
		else $error("activity heard before arming");
	chk_wp_lock: assert property (@(posedge sclk_in) disable iff (sel_n_in)
		(!wp_s2 && armed_s2) |=> $stable(bp_hi_reg) && $stable(bp_lo_reg))
		else $error("protect bits changed under lock");
	chk_bad_cmd: assert property (@(posedge sclk_in) disable iff (sel_n_in)
		(byte_end && st_reg == sef_pkg::ST_CMD && !cmd_ok(rx_next, busy_s2))
		|=> standby_reg && !drv_reg)
		else $error("unknown command left device active");
	chk_page_wrap: assert property (@(posedge sclk_in) disable iff (sel_n_in)
		(byte_end && st_reg == sef_pkg::ST_WDATA)
		|=> addr_reg[sef_pkg::ADDR_W-1:sef_pkg::PAGE_W] == $past(addr_reg[sef_pkg::ADDR_W-1:sef_pkg::PAGE_W]))
		else $error("page write left its page");
endmodule // sef_spi_front
`default_nettype wire

// *** hw/sef_pkg.sv ***
// Shared constants and types for the serial EEPROM SPI front end
package sef_pkg;
	// ==========================================
	// Array geometry
	localparam int ADDR_W = 12;
	localparam int MEM_BYTES = 4096;
	localparam int PAGE_W = 5;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 12'h001;
	localparam logic [PAGE_W-1:0] PAGE_ONE = 5'h01;
	localparam logic [1:0] TOP_QUARTER = 2'h3;
	// ==========================================
	// Command codes
	localparam logic [7:0] CMD_WRSR = 8'h01;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_RDSR = 8'h05;
	localparam logic [7:0] CMD_WREN = 8'h06;
	// ==========================================
	// Status byte layout
	localparam int SR_BUSY = 0;
	localparam int SR_WEL = 1;
	localparam int SR_BP_LO = 2;
	localparam int SR_BP_HI = 3;
	localparam logic [7:0] SR_CLEAR = 8'h00;
	// ==========================================
	// Bit counter
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_ONE = 3'h1;
	// ==========================================
	// Write cycle timing
	localparam int MCLK_HZ = 20000000;
	localparam int WR_TIME_MS = 5;
	localparam int MS_PER_S = 1000;
	localparam int WR_CYCLES = (WR_TIME_MS * (MCLK_HZ / MS_PER_S));
	// ==========================================
	// Frame states
	typedef enum logic [5:0] {
		ST_CMD = 6'h01,
		ST_ADDR = 6'h02,
		ST_WDATA = 6'h04,
		ST_RDATA = 6'h08,
		ST_SRIN = 6'h10,
		ST_DONE = 6'h20
	} sef_state_t;
endpackage

// *** hw/sef_sync_if.sv ***
// Crossing signals between the link logic and the write cycle timer
`timescale 1ns/100ps
`default_nettype none
interface sef_sync_if;
	logic armed;
	logic busy;
	logic wr_tgl;
	modport ctl (output armed, output busy, input wr_tgl);
	modport link (input armed, input busy, output wr_tgl);
endinterface
`default_nettype wire

// *** hw/sef_wr_timer.sv ***
// Master clock side: power-up arming and the internal write cycle timer
`timescale 1ns/100ps
`default_nettype none
module sef_wr_timer #(
	parameter int WR_CYCLES = sef_pkg::WR_CYCLES
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic resetn_in,
	// Select pin
	input wire logic sel_n_in,
	// Crossing signals
	sef_sync_if.ctl sync
);
	localparam int CNT_W = $clog2(WR_CYCLES + 1);
	logic sel_s1_reg, sel_s2_reg, sel_s3_reg;
	logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
	logic armed_reg, pend_reg, busy_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic sel_fall, sel_rise, wr_seen, start;

	// ==========================================
	// Synchronisers
	always_ff @(posedge mclk_in) begin
		sel_s1_reg <= sel_n_in;
		sel_s2_reg <= sel_s1_reg;
		tgl_s1_reg <= sync.wr_tgl;
		tgl_s2_reg <= tgl_s1_reg;
	end
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			sel_s3_reg <= 1'b1;
			tgl_s3_reg <= tgl_s2_reg;
		end else begin
			sel_s3_reg <= sel_s2_reg;
			tgl_s3_reg <= tgl_s2_reg;
		end
	end
	assign sel_fall = sel_s3_reg && !sel_s2_reg;
	assign sel_rise = !sel_s3_reg && sel_s2_reg;
	assign wr_seen = tgl_s2_reg ^ tgl_s3_reg;
	assign start = sel_rise && (pend_reg || wr_seen);

	// ==========================================
	// Arming: nothing is heard before the first select fall
	always_ff @(posedge mclk_in) begin
		if (!resetn_in)
			armed_reg <= 1'b0;
		else if (sel_fall)
			armed_reg <= 1'b1;
	end

	// ==========================================
	// Write cycle: starts when the writing frame ends
	always_ff @(posedge mclk_in) begin
		if (!resetn_in)
			pend_reg <= 1'b0;
		else if (start)
			pend_reg <= 1'b0;
		else if (wr_seen)
			pend_reg <= 1'b1;
	end
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			busy_reg <= 1'b0;
			cnt_reg <= '0;
		end else if (start) begin
			busy_reg <= 1'b1;
			cnt_reg <= CNT_W'(WR_CYCLES - 1);
		end else if (busy_reg) begin
			if (cnt_reg == '0)
				busy_reg <= 1'b0;
			else
				cnt_reg <= cnt_reg - CNT_W'(1);
		end
	end
	assign sync.armed = armed_reg;
	assign sync.busy = busy_reg;

	// ==========================================
	// Checks
	chk_busy_load: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		$rose(busy_reg) |-> cnt_reg == CNT_W'(WR_CYCLES - 1))
		else $error("write timer loaded wrong count");
	chk_busy_end: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(busy_reg && cnt_reg == '0 && !start) |=> !busy_reg)
		else $error("write cycle overran");
	chk_arm_edge: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(!armed_reg && !sel_fall) |=> !armed_reg)
		else $error("armed without a select fall");
endmodule // sef_wr_timer
`default_nettype wire

// *** tb/sef_spi_master.sv ***
// SPI bus master model for the serial EEPROM front end
`timescale 1ns/100ps
`default_nettype none
module sef_spi_master (
	// Serial link
	output logic sclk_out,
	output logic sel_n_out,
	output logic mosi_out,
	output logic hold_n_out,
	output logic wp_n_out
);
	// ==========================================
	// Link state
	bit cpol;
	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		mosi_out = 1'b0;
		hold_n_out = 1'b1;
		wp_n_out = 1'b1;
		cpol = 1'b0;
	end
	// Released data line keeps moving so a stale bit cannot pass for a real one
	always #30 if (sel_n_out) mosi_out = ~mosi_out;
	// ==========================================
	// Frame tasks
	task automatic frame(input logic [7:0] bytes[$], input int pause_at, input bit stay);
		int n;
		n = 0;
		sclk_out = cpol;
		#20;
		sel_n_out = 1'b0;
		#20;
		foreach (bytes[i]) begin
			for (int b = 7; b >= 0; b--) begin
				sclk_out = 1'b0;
				mosi_out = bytes[i][b];
				if (n == pause_at) begin
					#5 hold_n_out = 1'b0;
					repeat (3) begin
						#15 sclk_out = 1'b1;
						mosi_out = ~mosi_out;
						#15 sclk_out = 1'b0;
					end
					mosi_out = bytes[i][b];
					#10 hold_n_out = 1'b1;
				end
				n++;
				#15 sclk_out = 1'b1;
				#15;
			end
		end
		if (!cpol) sclk_out = 1'b0;
		#20;
		if (!stay) deselect();
	endtask
	task automatic deselect();
		sel_n_out = 1'b1;
		#200;
	endtask
endmodule // sef_spi_master
`default_nettype wire

// *** tb/sef_spi_front_test.sv ***
// Self-checking bench for the serial EEPROM SPI front end
`timescale 1ns/100ps
`default_nettype none
module sef_spi_front_test;
	// ==========================================
	// Signals
	localparam int WRC = 50;
	logic mclk, resetn, sclk, sel_n, mosi, hold_n, wp_n;
	logic miso, miso_oe, active, busy;
	int n_fail, total_checks, nb, len;
	logic [15:0] notes[$];
	logic [15:0] note;
	logic [7:0] sh, d0, d1;
	logic [31:0] rng;
	initial mclk = 1'b0;
	always #25 mclk = ~mclk;
	sef_spi_master PM (
		.sclk_out(sclk),
		.sel_n_out(sel_n),
		.mosi_out(mosi),
		.hold_n_out(hold_n),
		.wp_n_out(wp_n)
	);
	sef_spi_front #(.WR_CYCLES(WRC)) DUT (
		.mclk_in(mclk),
		.resetn_in(resetn),
		.sclk_in(sclk),
		.sel_n_in(sel_n),
		.mosi_in(mosi),
		.hold_n_in(hold_n),
		.wp_n_in(wp_n),
		.miso_out(miso),
		.miso_oe_out(miso_oe),
		.active_out(active),
		.busy_out(busy)
	);
	// ==========================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic rdsr(input logic [7:0] exp, input logic [7:0] mask, input int pause_at);
		notes.push_back({mask, exp});
		PM.frame('{sef_pkg::CMD_RDSR, 8'h00}, pause_at, 0);
	endtask
	// Waits out a write cycle; the closing frame lets the link side see busy drop
	task automatic settle();
		int t;
		len = 0;
		for (t = 0; t < 10 && busy !== 1'b1; t++) @(posedge mclk);
		for (t = 0; t < 4 * WRC && busy === 1'b1; t++) begin
			@(posedge mclk);
			len++;
		end
		if (busy !== 1'b0) begin
			check(8'h01, 8'h00);
			conclude();
		end
		PM.frame('{sef_pkg::CMD_WRDI}, -1, 0);
	endtask
	// ==========================================
	// Output watchers
	always @(posedge sclk or posedge sel_n) begin
		if (sel_n) nb = 0;
		else if (hold_n && miso_oe === 1'b1) begin
			sh = {sh[6:0], miso};
			nb++;
			if (nb == 8) begin
				nb = 0;
				// Unexpected output byte
				if (notes.size() == 0) check(8'h01, 8'h00);
				else begin
					note = notes.pop_front();
					check(sh & note[15:8], note[7:0] & note[15:8]);
				end
			end
		end
	end
	always @(posedge sclk or posedge sel_n) begin
		#2;
		if (sel_n || !hold_n) check(8'(miso_oe), 8'h00);
	end
	// ==========================================
	// Main sequence
	initial begin
		resetn = 1'b0;
		rng = 32'h2ad7;
		n_fail = 0;
		total_checks = 0;
		nb = 0;
		repeat (16) @(posedge mclk);
		#1 resetn = 1'b1;
		repeat (2) @(posedge mclk);
		// Arming frame: a read here must stay silent
		PM.frame('{sef_pkg::CMD_RDSR, 8'h00}, -1, 0);
		for (int m = 0; m < 2; m++) begin
			PM.cpol = m[0];
			rdsr(8'h00, 8'hf3, -1);
			PM.frame('{sef_pkg::CMD_WREN}, -1, 1);
			#1 check(8'(active), 8'h01);
			PM.deselect();
			rdsr(8'h02, 8'hf3, 11);
			d0 = rng[7:0];
			rng = xs(rng);
			d1 = rng[7:0];
			rng = xs(rng);
			PM.frame('{sef_pkg::CMD_WRITE, 8'h00, 8'h1f, d0, d1}, -1, 0);
			settle();
			check(8'(len >= WRC - 1 && len <= WRC + 1), 8'h01);
			notes.push_back({8'hff, d1});
			PM.frame('{sef_pkg::CMD_READ, 8'h00, 8'h00, 8'h00}, -1, 0);
			notes.push_back({8'hff, d0});
			PM.frame('{sef_pkg::CMD_READ, 8'h00, 8'h1f, 8'h00}, -1, 0);
			// Unknown code drops to standby until the next select
			PM.frame('{8'ha5, 8'h00}, -1, 1);
			#1 check(8'(active), 8'h00);
			check(8'(miso_oe), 8'h00);
			PM.deselect();
			// Protect bits follow a status write only while protection is open
			PM.wp_n_out = 1'b1;
			PM.frame('{sef_pkg::CMD_WREN}, -1, 0);
			PM.frame('{sef_pkg::CMD_WRSR, 8'h04}, -1, 0);
			settle();
			rdsr(8'h04, 8'hff, -1);
			PM.wp_n_out = 1'b0;
			PM.frame('{sef_pkg::CMD_WREN}, -1, 0);
			PM.frame('{sef_pkg::CMD_WRSR, 8'h00}, -1, 0);
			settle();
			rdsr(8'h04, 8'h0c, -1);
		end
		check(8'(notes.size()), 8'h00);
		conclude();
	end
endmodule // sef_spi_front_test
`default_nettype wire
